// ==== scd_decoder.sv ====
// Socket command decoder: command byte, pointers and action requests
`timescale 1ns/1ps
`include "scd_consts.svh"
// How it works
// [RL1] Close code shuts the socket and sets status to closed.
// [RL2] Send transmits all bytes between transmit read and write pointers.
// [RL3] Manual-address send, datagram only: send with host address, no lookup.
// [RL4] Host uses manual-address send only in datagram, address written first.
// [RL5] Keep-alive in stream sends one byte; timeout interrupt on silence or end.
// [RL6] Receive consumes data to read pointer and recomputes received size.
// [RL7] Command byte returns to zero once the command is accepted.
module scd_decoder #(
  parameter int PTR_W = 16,
  parameter int BUF_BYTES = `SCD_BUF_BYTES,
  parameter int KA_CYC =
    (`SCD_KA_TIMEOUT_NS + `SCD_CLK_NS - 1) / `SCD_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [`SCD_ADDR_W-1:0] reg_addr,
  input wire logic [`SCD_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SCD_DATA_W-1:0] reg_rdata,
  output logic irq,
  input wire logic [PTR_W-1:0] rx_write_pointer,
  input wire logic tx_done,
  input wire logic ka_reply,
  input wire logic conn_lost,
  output logic tx_req,
  output logic tx_manual,
  output logic [PTR_W-1:0] tx_start,
  output logic [PTR_W-1:0] tx_len,
  output logic [47:0] tx_dest_hw,
  output logic ka_req,
  output logic close_req
);
  localparam int KA_W = $clog2(KA_CYC + 1);
  localparam logic [KA_W-1:0] KA_LAST = KA_W'(KA_CYC - 1);
  localparam logic [PTR_W-1:0] BUF_SZ = PTR_W'(BUF_BYTES);

  typedef struct packed {
    scd_pkg::scd_fsm_e state;
    logic [7:0] cmd;
    scd_pkg::scd_mode_e mode;
    logic [7:0] status;
    logic [PTR_W-1:0] tx_wr;
    logic [PTR_W-1:0] tx_rd;
    logic [PTR_W-1:0] rx_rd;
    logic [PTR_W-1:0] rx_size;
    logic [47:0] dha;
    logic tx_req;
    logic tx_manual;
    logic [PTR_W-1:0] tx_len;
    logic ka_req;
    logic close_req;
    logic [KA_W-1:0] ka_cnt;
    logic [`SCD_EV_W-1:0] ev;
    logic [`SCD_DATA_W-1:0] rdata;
  } scd_core_s;

  scd_core_s st_r;
  scd_core_s st_nxt;
  logic accept;
  logic [`SCD_EV_W-1:0] int_stat;
  logic [`SCD_EV_W-1:0] int_en;
  logic [`SCD_EV_W-1:0] int_clr;
  logic int_en_we;
  logic [PTR_W-1:0] tx_used;

  assign accept = (st_r.state == scd_pkg::SCD_IDLE) &&
                  (st_r.cmd != `SCD_CMD_NONE);
  assign tx_used = st_r.tx_wr - st_r.tx_rd;
  assign int_en_we = reg_wr && (reg_addr == `SCD_OFF_INT_EN);
  assign int_clr = (reg_wr && reg_addr == `SCD_OFF_INT_CLR) ?
                   reg_wdata[`SCD_EV_W-1:0] : '0;

  // Host writes, command decode, sequencing and read mux
  always_comb begin
    st_nxt = st_r;
    st_nxt.tx_req = 1'b0;
    st_nxt.ka_req = 1'b0;
    st_nxt.close_req = 1'b0;
    st_nxt.ev = '0;
    st_nxt.rdata = '0;
    // Command execution when idle
    if (accept) begin
      // [RL7] Clear on accept
      st_nxt.cmd = `SCD_CMD_NONE;
      unique case (st_r.cmd)
        `SCD_CMD_CLOSE: begin
          // [RL1] Close sets closed
          st_nxt.mode = scd_pkg::SCD_MODE_CLOSED;
          st_nxt.status = `SCD_STAT_CLOSED;
          st_nxt.close_req = 1'b1;
          st_nxt.ev[`SCD_EV_CLOSED] = 1'b1;
        end
        `SCD_CMD_SEND, `SCD_CMD_SEND_MANUAL_HW_ADDR_CMD: begin
          // [RL2] Send whole queue
          if (st_r.mode != scd_pkg::SCD_MODE_CLOSED &&
              (st_r.cmd == `SCD_CMD_SEND ||
               st_r.mode == scd_pkg::SCD_MODE_DGRAM)) begin
            st_nxt.tx_req = 1'b1;
            st_nxt.tx_len = tx_used;
            // [RL3] Host address, no lookup
            st_nxt.tx_manual = (st_r.cmd == `SCD_CMD_SEND_MANUAL_HW_ADDR_CMD);
            st_nxt.state = scd_pkg::SCD_SEND;
          end
        end
        `SCD_CMD_KEEPALIVE: begin
          // [RL5] One-byte probe
          if (st_r.mode == scd_pkg::SCD_MODE_STREAM) begin
            st_nxt.ka_req = 1'b1;
            st_nxt.ka_cnt = '0;
            st_nxt.state = scd_pkg::SCD_PROBE;
          end
        end
        `SCD_CMD_RECEIVE_ACK_CMD: begin
          // [RL6] Recompute received size
          st_nxt.rx_size = rx_write_pointer - st_r.rx_rd;
        end
        default: begin
          st_nxt.cmd = `SCD_CMD_NONE;
        end
      endcase
    end
    // Wait for the transmit engine
    if (st_r.state == scd_pkg::SCD_SEND && tx_done) begin
      // [RL2] Queue drained
      st_nxt.tx_rd = st_r.tx_rd + st_r.tx_len;
      st_nxt.ev[`SCD_EV_SENT] = 1'b1;
      st_nxt.state = scd_pkg::SCD_IDLE;
    end
    // Wait for a probe answer
    if (st_r.state == scd_pkg::SCD_PROBE) begin
      st_nxt.ka_cnt = st_r.ka_cnt + KA_W'(1);
      if (ka_reply && !conn_lost) begin
        st_nxt.state = scd_pkg::SCD_IDLE;
      end else if (conn_lost || st_r.ka_cnt == KA_LAST) begin
        // [RL5] Timeout interrupt
        st_nxt.ev[`SCD_EV_TIMEOUT] = 1'b1;
        st_nxt.state = scd_pkg::SCD_IDLE;
      end
    end
    // Host register writes; a new command write wins over the clear
    if (reg_wr) begin
      unique case (reg_addr)
        `SCD_OFF_CMD: st_nxt.cmd = reg_wdata[7:0];
        `SCD_OFF_MODE: begin
          if (reg_wdata[1:0] == scd_pkg::SCD_MODE_STREAM) begin
            st_nxt.mode = scd_pkg::SCD_MODE_STREAM;
            st_nxt.status = `SCD_STAT_STREAM;
          end else if (reg_wdata[1:0] == scd_pkg::SCD_MODE_DGRAM) begin
            st_nxt.mode = scd_pkg::SCD_MODE_DGRAM;
            st_nxt.status = `SCD_STAT_DGRAM;
          end
        end
        `SCD_OFF_TX_WR: st_nxt.tx_wr = reg_wdata[PTR_W-1:0];
        `SCD_OFF_RX_RD: st_nxt.rx_rd = reg_wdata[PTR_W-1:0];
        // Destination address words
        `SCD_OFF_DHA0: st_nxt.dha[15:0] = reg_wdata;
        `SCD_OFF_DHA1: st_nxt.dha[31:16] = reg_wdata;
        `SCD_OFF_DHA2: st_nxt.dha[47:32] = reg_wdata;
        default: st_nxt.cmd = st_nxt.cmd;
      endcase
    end
    // Read data for the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        `SCD_OFF_CMD: st_nxt.rdata = {8'h00, st_r.cmd};
        `SCD_OFF_MODE: st_nxt.rdata = {14'h0000, st_r.mode};
        `SCD_OFF_STATUS: st_nxt.rdata = {8'h00, st_r.status};
        `SCD_OFF_INT_STAT: st_nxt.rdata = {13'h0000, int_stat};
        `SCD_OFF_INT_EN: st_nxt.rdata = {13'h0000, int_en};
        `SCD_OFF_TX_WR: st_nxt.rdata = st_r.tx_wr;
        `SCD_OFF_TX_RD: st_nxt.rdata = st_r.tx_rd;
        `SCD_OFF_TX_FREE: st_nxt.rdata = BUF_SZ - tx_used;
        `SCD_OFF_RX_WR: st_nxt.rdata = rx_write_pointer;
        `SCD_OFF_RX_RD: st_nxt.rdata = st_r.rx_rd;
        `SCD_OFF_RX_SIZE: st_nxt.rdata = st_r.rx_size;
        `SCD_OFF_DHA0: st_nxt.rdata = st_r.dha[15:0];
        `SCD_OFF_DHA1: st_nxt.rdata = st_r.dha[31:16];
        `SCD_OFF_DHA2: st_nxt.rdata = st_r.dha[47:32];
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= scd_pkg::SCD_IDLE;
      st_r.mode <= scd_pkg::SCD_MODE_CLOSED;
      st_r.status <= `SCD_STAT_CLOSED;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Event flags and interrupt line
  scd_sticky_irq #(
    .W(`SCD_EV_W)
  ) u_irq (
    .core_clk(core_clk),
    .rst(rst),
    .set_i(st_r.ev),
    .clr_i(int_clr),
    .en_we_i(int_en_we),
    .en_i(reg_wdata[`SCD_EV_W-1:0]),
    .stat_o(int_stat),
    .en_o(int_en),
    .irq_o(irq)
  );

  assign reg_rdata = st_r.rdata;
  assign tx_req = st_r.tx_req;
  assign tx_manual = st_r.tx_manual;
  assign tx_start = st_r.tx_rd;
  assign tx_len = st_r.tx_len;
  assign tx_dest_hw = st_r.dha;
  assign ka_req = st_r.ka_req;
  assign close_req = st_r.close_req;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_acc(logic [7:0] c);
    accept && st_r.cmd == c && !(reg_wr && reg_addr == `SCD_OFF_CMD);
  endsequence

  a_cmd_cleared: assert property ( // [RL7]
    accept && !(reg_wr && reg_addr == `SCD_OFF_CMD)
    |=> st_r.cmd == `SCD_CMD_NONE)
    else $error("command byte not cleared after accept");
  a_close_status: assert property ( // [RL1]
    s_acc(`SCD_CMD_CLOSE) |=> st_r.status == `SCD_STAT_CLOSED && close_req
      ##1 !close_req)
    else $error("close did not reach closed state");
  a_send_len: assert property ( // [RL2]
    s_acc(`SCD_CMD_SEND) ##0 st_r.mode != scd_pkg::SCD_MODE_CLOSED
    |=> tx_req && !tx_manual && tx_len == $past(tx_used))
    else $error("send request length wrong");
  a_send_drain: assert property ( // [RL2]
    st_r.state == scd_pkg::SCD_SEND && tx_done
    |=> st_r.tx_rd == $past(st_r.tx_rd + st_r.tx_len)
    ##1 int_stat[`SCD_EV_SENT])
    else $error("read pointer not advanced after send");
  a_mac_dgram: assert property ( // [RL3]
    s_acc(`SCD_CMD_SEND_MANUAL_HW_ADDR_CMD) ##0 st_r.mode == scd_pkg::SCD_MODE_DGRAM
    |=> tx_req && tx_manual && tx_dest_hw == $past(st_r.dha))
    else $error("manual-address send not issued");
  a_mac_stream: assert property ( // [RL3]
    s_acc(`SCD_CMD_SEND_MANUAL_HW_ADDR_CMD) ##0 st_r.mode == scd_pkg::SCD_MODE_STREAM
    |=> !tx_req && st_r.state == scd_pkg::SCD_IDLE)
    else $error("manual-address send ran outside datagram mode");
  a_probe_once: assert property ( // [RL5]
    s_acc(`SCD_CMD_KEEPALIVE) ##0 st_r.mode == scd_pkg::SCD_MODE_STREAM
    |=> ka_req ##1 !ka_req)
    else $error("keep-alive probe not a single request");
  a_probe_timeout: assert property ( // [RL5]
    st_r.state == scd_pkg::SCD_PROBE && !ka_reply &&
    (conn_lost || st_r.ka_cnt == KA_LAST)
    |=> st_r.ev[`SCD_EV_TIMEOUT] ##1 int_stat[`SCD_EV_TIMEOUT])
    else $error("timeout interrupt missing");
  a_rx_size: assert property ( // [RL6]
    s_acc(`SCD_CMD_RECEIVE_ACK_CMD)
    |=> st_r.rx_size == $past(rx_write_pointer - st_r.rx_rd))
    else $error("received size not recomputed");
endmodule

// ==== scd_consts.svh ====
// Offsets, field values and timing figures of the socket command decoder
`ifndef SCD_CONSTS_SVH
`define SCD_CONSTS_SVH
`define SCD_ADDR_W 5
`define SCD_DATA_W 16
`define SCD_OFF_CMD 5'h00
`define SCD_OFF_MODE 5'h01
`define SCD_OFF_STATUS 5'h02
`define SCD_OFF_INT_STAT 5'h03
`define SCD_OFF_INT_CLR 5'h04
`define SCD_OFF_INT_EN 5'h05
`define SCD_OFF_TX_WR 5'h06
`define SCD_OFF_TX_RD 5'h07
`define SCD_OFF_TX_FREE 5'h08
`define SCD_OFF_RX_WR 5'h09
`define SCD_OFF_RX_RD 5'h0a
`define SCD_OFF_RX_SIZE 5'h0b
`define SCD_OFF_DHA0 5'h0c
`define SCD_OFF_DHA1 5'h0d
`define SCD_OFF_DHA2 5'h0e
`define SCD_CMD_NONE 8'h00
`define SCD_CMD_CLOSE 8'h10
`define SCD_CMD_SEND 8'h20
`define SCD_CMD_SEND_MANUAL_HW_ADDR_CMD 8'h21
`define SCD_CMD_KEEPALIVE 8'h22
`define SCD_CMD_RECEIVE_ACK_CMD 8'h40
`define SCD_STAT_CLOSED 8'h00
`define SCD_STAT_STREAM 8'h01
`define SCD_STAT_DGRAM 8'h02
`define SCD_EV_SENT 0
`define SCD_EV_TIMEOUT 1
`define SCD_EV_CLOSED 2
`define SCD_EV_W 3
`define SCD_CLK_NS 4
`define SCD_KA_TIMEOUT_NS 2000
`define SCD_BUF_BYTES 2048
`endif

// ==== scd_pkg.sv ====
// Types shared by the socket command decoder
package scd_pkg;
  typedef enum logic [2:0] {
    SCD_IDLE = 3'h1,
    SCD_SEND = 3'h2,
    SCD_PROBE = 3'h4
  } scd_fsm_e;
  typedef enum logic [1:0] {
    SCD_MODE_CLOSED = 2'h0,
    SCD_MODE_STREAM = 2'h1,
    SCD_MODE_DGRAM = 2'h2
  } scd_mode_e;
endpackage

// ==== scd_sticky_irq.sv ====
// Sticky interrupt status with clear, enable and one level output
`timescale 1ns/1ps
module scd_sticky_irq #(
  parameter int W = 3
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  input wire logic en_we_i,
  input wire logic [W-1:0] en_i,
  output logic [W-1:0] stat_o,
  output logic [W-1:0] en_o,
  output logic irq_o
);
  typedef struct packed {
    logic [W-1:0] stat;
    logic [W-1:0] en;
    logic irq;
  } scd_irq_s;
  scd_irq_s st_r;
  scd_irq_s st_nxt;

  // Set wins over a clear in the same cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.stat = (st_r.stat & ~clr_i) | set_i;
    if (en_we_i) begin
      st_nxt.en = en_i;
    end
    st_nxt.irq = |(st_nxt.stat & st_nxt.en);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stat_o = st_r.stat;
  assign en_o = st_r.en;
  assign irq_o = st_r.irq;

  // [RL5] Enabled event raises line
  a_irq_level: assert property ( // [RL5]
    @(posedge core_clk) disable iff (rst)
    |(set_i & (en_we_i ? en_i : en_o)) |=> irq_o)
    else $error("enabled event did not raise the interrupt");
endmodule

// ==== scd_net_model.sv ====
// Network side model: transmit engine and keep-alive peer
`timescale 1ns/1ps
module scd_net_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic tx_req,
  input wire logic ka_req,
  input wire logic slow,
  input wire logic [1:0] ka_mode,
  output logic tx_done,
  output logic ka_reply,
  output logic conn_lost
);
  logic [3:0] tx_cnt_r;
  logic [3:0] ka_cnt_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_r <= 4'h0;
      ka_cnt_r <= 4'h0;
    end else begin
      tx_cnt_r <= tx_req ? (slow ? 4'hc : 4'h2) :
        tx_cnt_r - {3'h0, tx_cnt_r != 4'h0};
      ka_cnt_r <= ka_req ? 4'h3 : ka_cnt_r - {3'h0, ka_cnt_r != 4'h0};
    end
  end
  // Done pulse when the short or long delay runs out
  assign tx_done = (tx_cnt_r == 4'h1);
  // peer answers, drops or stays silent
  assign ka_reply = (ka_mode == 2'h1) && (ka_cnt_r == 4'h1);
  assign conn_lost = (ka_mode == 2'h2) && (ka_cnt_r == 4'h1);
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the socket command decoder
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] rx_wp = 16'h0000;
  logic slow = 1'b0;
  logic [1:0] ka_mode = 2'h1;
  logic [15:0] reg_rdata, tx_start, tx_len, len, len2, p;
  logic [47:0] tx_dest_hw;
  logic irq, tx_done, ka_reply, conn_lost, tx_req, tx_manual;
  logic ka_req, close_req;
  logic rd_q = 1'b0;
  logic [15:0] rq[$];
  logic [19:0] pq[$];
  logic [19:0] e;
  logic [31:0] seed = 32'h0000f6c7;
  int bad_count = 0;
  int checks = 0;

  scd_decoder #(.KA_CYC(8)) i_scd_decoder (.core_clk(core_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .rx_write_pointer(rx_wp), .tx_done(tx_done), .ka_reply(ka_reply),
    .conn_lost(conn_lost), .tx_req(tx_req), .tx_manual(tx_manual),
    .tx_start(tx_start), .tx_len(tx_len), .tx_dest_hw(tx_dest_hw),
    .ka_req(ka_req), .close_req(close_req));
  scd_net_model i_scd_net_model (.core_clk(core_clk), .rst(rst),
    .tx_req(tx_req), .ka_req(ka_req), .slow(slow), .ka_mode(ka_mode),
    .tx_done(tx_done), .ka_reply(ka_reply), .conn_lost(conn_lost));

  // Clock
  initial begin
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic chk(logic [47:0] got, logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Read data against its note
  task automatic chk_rd(logic [15:0] got, logic [15:0] exp);
    chk({32'h0, got}, {32'h0, exp});
  endtask

  // Request pulse against its note
  task automatic chk_req(logic [19:0] got, logic [19:0] exp);
    chk({28'h0, got}, {28'h0, exp});
  endtask

  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [4:0] a, logic [15:0] x);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    rq.push_back(x);
  endtask

  // Note the request pulse a command should give, then write it
  task automatic cmd(logic [7:0] c, logic [2:0] r, logic [15:0] n,
                     logic m);
    if (r != 3'h0) pq.push_back({r, m, n});
    wr(5'h00, {8'h00, c});
  endtask

  task automatic wait_irq(logic lv);
    int n;
    n = 0;
    while (irq !== lv && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk({47'h0, irq}, {47'h0, lv});
  endtask

  task automatic done(string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare read data and request pulses with the oldest notes
  always @(posedge core_clk) begin
    if (rd_q) chk_rd(reg_rdata, rq.pop_front());
    rd_q <= reg_rd;
    if (tx_req | ka_req | close_req) begin
      if (pq.size() == 0) begin
        chk_req(20'h00001, 20'h00000);
      end else begin
        e = pq.pop_front();
        chk_req({close_req, ka_req, tx_req,
                 e[17] ? {tx_manual, tx_len} : e[16:0]}, e);
      end
    end
  end

  // Watchdog
  initial begin
    #200000;
    bad_count++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(5'h02, 16'h0000);
    rd(5'h1f, 16'h0000);
    wr(5'h05, 16'h0007);
    rd(5'h05, 16'h0007);
    cmd(8'h20, 3'h0, 16'h0, 1'b0);
    rd(5'h00, 16'h0000);
    // Unknown code is dropped and cleared
    cmd(8'h33, 3'h0, 16'h0, 1'b0);
    rd(5'h00, 16'h0000);
    done("reset");
    wr(5'h01, 16'h0002);
    // Mode code 3 is ignored
    wr(5'h01, 16'h0003);
    rd(5'h01, 16'h0002);
    rd(5'h02, 16'h0002);
    len = rnd() & 16'h03ff;
    wr(5'h06, len);
    rd(5'h06, len);
    wr(5'h07, 16'h0123);
    rd(5'h07, 16'h0000);
    rd(5'h08, 16'h0800 - len);
    wr(5'h0c, 16'h1a2b);
    wr(5'h0d, 16'h3c4d);
    wr(5'h0e, 16'h5e6f);
    rd(5'h0d, 16'h3c4d);
    cmd(8'h21, 3'h1, len, 1'b1);
    wait_irq(1'b1);
    rd(5'h03, 16'h0001);
    chk(tx_dest_hw, 48'h5e6f3c4d1a2b);
    chk({32'h0, tx_start}, {32'h0, len});
    rd(5'h08, 16'h0800);
    wr(5'h04, 16'h0001);
    wait_irq(1'b0);
    cmd(8'h22, 3'h0, 16'h0, 1'b0);
    rd(5'h00, 16'h0000);
    done("datagram");
    wr(5'h01, 16'h0001);
    cmd(8'h21, 3'h0, 16'h0, 1'b0);
    cmd(8'h22, 3'h2, 16'h0, 1'b0);
    repeat (20) @(posedge core_clk);
    rd(5'h03, 16'h0000);
    for (int m = 0; m < 3; m += 2) begin
      ka_mode <= m[1:0];
      cmd(8'h22, 3'h2, 16'h0, 1'b0);
      wait_irq(1'b1);
      rd(5'h03, 16'h0002);
      wr(5'h04, 16'h0002);
      wait_irq(1'b0);
    end
    done("keepalive");
    p = (rnd() & 16'h03ff) + 16'h0010;
    rx_wp <= p;
    wr(5'h0a, 16'h0010);
    rd(5'h0a, 16'h0010);
    rd(5'h09, p);
    rd(5'h0b, 16'h0000);
    cmd(8'h40, 3'h0, 16'h0, 1'b0);
    rd(5'h0b, p - 16'h0010);
    done("receive");
    wr(5'h01, 16'h0001);
    slow <= 1'b1;
    len2 = rnd() & 16'h03ff;
    wr(5'h06, len + len2);
    cmd(8'h20, 3'h1, len2, 1'b0);
    cmd(8'h10, 3'h4, 16'h0, 1'b0);
    wait_irq(1'b1);
    rd(5'h00, 16'h0000);
    rd(5'h03, 16'h0005);
    rd(5'h02, 16'h0000);
    repeat (4) @(posedge core_clk);
    chk(48'(pq.size()), 48'h0);
    done("busy close");
    close_out();
  end
endmodule
